// ---- rtl/accel_defs.svh ----
`ifndef ACCEL_DEFS_SVH
`define ACCEL_DEFS_SVH
// timing
`define ALM_CLK_HZ      25000000
`define ALM_TICK_MS     100
`define ALM_HOLD_MS     1000
`define ALM_SHOW_MS     1000
// limits and sizes
`define ALM_SPEED_HYST  17'h0_0003
`define ALM_LINES_MAX   16'h4E20
`define ALM_CASES_MAX   5'h14
`define ALM_CASE_LINES  10'h0384
`define ALM_SINT_MIN    10'h001
`define ALM_SINT_MAX    10'h258
`define ALM_FILT_UNIT   8'h0A
`define ALM_FILT_OFF    8'h01
`define ALM_MARKER_RST  16'h0001
// blink codes in ticks
`define BLK_ON_TICKS    4'h2
`define BLK_OFF_TICKS   4'h2
`define BLK_GAP_TICKS   4'hA
`define BLK_NONE        4'h0
`define BLK_FIRST       4'h2
`define BLK_BOOT        4'hF
// register byte addresses
`define RA_WARN_MAX     8'h00
`define RA_WARN_MIN     8'h04
`define RA_ALARM_MAX    8'h08
`define RA_ALARM_MIN    8'h0C
`define RA_CTRL         8'h10
`define RA_SPEED_SET    8'h14
`define RA_TIMEOUT      8'h18
`define RA_FILTER       8'h1C
`define RA_SAMPLE_INT   8'h20
`define RA_DELETE       8'h24
`define RA_STATUS       8'h28
`define RA_MARKER       8'h2C
`define RA_LINES        8'h30
`define RA_EVT_SEL      8'h34
`define RA_EVT_VAL      8'h38
`define RA_EVT_TIME     8'h3C
`define RA_OPTIME       8'h40
// control fields
`define CF_TRIG         1:0
`define CF_ALARM        3:2
`define CF_LAMP         5:4
`define CF_TIMER        6
// reset values
`define RV_WARN_MAX     16'h015E
`define RV_WARN_MIN     16'hFF9C
`define RV_ALARM_MAX    16'h0190
`define RV_ALARM_MIN    16'hFF38
`define RV_CTRL         7'h15
`define RV_SPEED_SET    16'h0064
`define RV_TIMEOUT      16'h0E10
`define RV_FILTER       8'h03
`define RV_SAMPLE_INT   10'h001
`endif

// ---- rtl/accel_lamp_blinker.sv ----
`timescale 1ns/10ps
`include "accel_defs.svh"
module accel_lamp_blinker (
	input  wire logic       clk_i,
	input  wire logic       rst_n_i,
	input  wire logic       ce_i,
	input  wire logic       tick_i,
	input  wire logic [3:0] code_i,
	output logic            lamp_o
);
	logic [3:0] t_ff;
	logic [3:0] n_ff;
	// groups of code_i pulses then a gap; boot code blinks without gap
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			t_ff   <= 4'h0;
			n_ff   <= 4'h0;
			lamp_o <= 1'b0;
		end
		else if (ce_i && tick_i)
		begin
			if (code_i == `BLK_NONE)
			begin
				t_ff   <= 4'h0;
				n_ff   <= 4'h0;
				lamp_o <= 1'b0;
			end
			else if (t_ff != 4'h0)
				t_ff <= t_ff - 4'h1;
			else if (lamp_o)
			begin
				lamp_o <= 1'b0;
				n_ff   <= n_ff + 4'h1;
				if (code_i == `BLK_BOOT || n_ff + 4'h1 < code_i)
					t_ff <= `BLK_OFF_TICKS - 4'h1;
				else
					t_ff <= `BLK_GAP_TICKS - 4'h1;
			end
			else
			begin
				lamp_o <= 1'b1;
				t_ff   <= `BLK_ON_TICKS - 4'h1;
				if (n_ff >= code_i)
					n_ff <= 4'h0;
			end
		end
	end
endmodule

// ---- rtl/accel_limit_monitor_recorder.sv ----
// What this block does
// RULE1: warning limit crossing drives annunciator, no storage
// RULE2: alarm crossing signals and stores exceeding value
// RULE3: recording inactive: warning signal only, no storage
// RULE4: recording gated by selectable trigger source
// RULE5: airspeed trigger with plus/minus 3 km/h hysteresis
// RULE6: optional timeout ends recording after set time
// RULE7: signalization mode off silences annunciator
// RULE8: button mode latches annunciator until clear press; code latches only on alarm crossings while recording
// RULE9: lamp shows exceedance or recording state
// RULE10: filter drops cycles below threshold; 0.1g off
// RULE11: host should program filter at least 0.3g
// RULE12: each memory area cleared independently by command
// RULE13: self-check pass: both outputs on one second
// RULE14: power-on faults reported on lamp, no measuring
// RULE15: lamp blink count encodes fault, continuous for boot
// RULE16: marker starts at 1, counts presses while recording
// RULE17: samples stored at 0.1-60 s into 20000 lines
// RULE18: up to 20 cases of 900 lines with hours
// RULE19: last 20 exceedance records and total time readable
// RULE20: exceed mode holds annunciator one extra second
// RULE21: lamp mode off, recording or exceedance
// RULE22: trigger auto, landing gear or airspeed threshold
// RULE23: each sample compared against four signed limits
// RULE24: settings in host-written storage, used next sample
`timescale 1ns/10ps
`include "accel_defs.svh"
module accel_limit_monitor_recorder import accel_pkg::*; #(
	parameter int TICK_CYCLES = `ALM_CLK_HZ / 1000 * `ALM_TICK_MS
) (
	input  wire logic               CLK_SYS_I,
	input  wire logic               RST_N_I,
	input  wire logic               CE_I,
	input  wire logic [7:0]         ADDR_I,
	input  wire logic [31:0]        WDATA_I,
	input  wire logic               WR_I,
	input  wire logic               RD_I,
	output logic      [31:0]        RDATA_O,
	input  wire logic signed [15:0] ACCEL_I,
	input  wire logic               ACCEL_VALID_I,
	input  wire logic [15:0]        AIRSPEED_I,
	input  wire logic               AIRSPEED_VALID_I,
	input  wire logic               GEAR_SW_I,
	input  wire logic               CLEAR_BTN_I,
	input  wire logic               MARKER_BTN_I,
	input  wire logic               SELFTEST_DONE_I,
	input  wire logic [6:0]         SELFTEST_FAULT_I,
	input  wire logic               FW_LOAD_I,
	output logic                    ANNUNC_O,
	output logic                    LAMP_O,
	output logic                    REC_ACTIVE_O,
	output logic                    REC_WR_O,
	output rec_word_type            REC_DATA_O,
	output logic [3:0]              DEL_O,
	output logic                    MEASURING_O
);
	localparam int TW         = $clog2(TICK_CYCLES + 1);
	localparam int HOLD_TICKS = `ALM_HOLD_MS / `ALM_TICK_MS;
	localparam int SHOW_TICKS = `ALM_SHOW_MS / `ALM_TICK_MS;
	localparam int SEC_TICKS  = 1000 / `ALM_TICK_MS;

	function automatic logic [3:0] fault_code(input logic [6:0] f);
		fault_code = `BLK_NONE;
		for (int i = 6; i >= 0; i--)
			if (f[i])
				fault_code = `BLK_FIRST + 4'(i);
	endfunction

	function automatic logic [9:0] clamp_sint(input logic [9:0] v);
		if (v < `ALM_SINT_MIN)
			clamp_sint = `ALM_SINT_MIN;
		else if (v > `ALM_SINT_MAX)
			clamp_sint = `ALM_SINT_MAX;
		else
			clamp_sint = v;
	endfunction

	//==========================================================
	// pins and time base
	//==========================================================
	logic gear_s, clr_s, mark_s, mark_d_ff;
	accel_pin_sync #(.W(3)) u_sync (
		.clk_i   (CLK_SYS_I),
		.rst_n_i (RST_N_I),
		.ce_i    (CE_I),
		.d_i     ({GEAR_SW_I, CLEAR_BTN_I, MARKER_BTN_I}),
		.q_o     ({gear_s, clr_s, mark_s})
	);

	logic [TW-1:0] tick_cnt_ff;
	logic          tick_ff;
	logic [3:0]    sec_div_ff;
	logic          sec_ff;
	always_ff @(posedge CLK_SYS_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
		begin
			tick_cnt_ff <= '0;
			tick_ff     <= 1'b0;
			sec_div_ff  <= 4'h0;
			sec_ff      <= 1'b0;
		end
		else if (CE_I)
		begin
			tick_ff <= (tick_cnt_ff == TW'(TICK_CYCLES - 1));
			tick_cnt_ff <= (tick_cnt_ff == TW'(TICK_CYCLES - 1)) ? '0 : tick_cnt_ff + 1'b1;
			sec_ff <= tick_ff && (sec_div_ff == 4'(SEC_TICKS - 1));
			if (tick_ff)
				sec_div_ff <= (sec_div_ff == 4'(SEC_TICKS - 1)) ? 4'h0 : sec_div_ff + 4'h1;
		end
	end

	//==========================================================
	// configuration registers
	//==========================================================
	logic signed [15:0] warn_max_ff, warn_min_ff, alarm_max_ff, alarm_min_ff;
	logic [6:0]  ctrl_ff;
	logic [15:0] speed_set_ff, timeout_ff;
	logic [7:0]  filter_ff;
	logic [9:0]  sint_ff;
	logic [4:0]  evt_sel_ff;
	trig_type       trig;
	alarm_mode_type amode;
	lamp_mode_type  lmode;
	assign trig  = trig_type'(ctrl_ff[`CF_TRIG]);
	assign amode = alarm_mode_type'(ctrl_ff[`CF_ALARM]);
	assign lmode = lamp_mode_type'(ctrl_ff[`CF_LAMP]);

	// host-written settings take effect from the next sample on (see RULE24)
	always_ff @(posedge CLK_SYS_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
		begin
			warn_max_ff  <= `RV_WARN_MAX;
			warn_min_ff  <= `RV_WARN_MIN;
			alarm_max_ff <= `RV_ALARM_MAX;
			alarm_min_ff <= `RV_ALARM_MIN;
			ctrl_ff      <= `RV_CTRL;
			speed_set_ff <= `RV_SPEED_SET;
			timeout_ff   <= `RV_TIMEOUT;
			filter_ff    <= `RV_FILTER;
			sint_ff      <= `RV_SAMPLE_INT;
			evt_sel_ff   <= 5'h00;
			DEL_O        <= 4'h0;
		end
		else if (CE_I)
		begin
			DEL_O <= (WR_I && ADDR_I == `RA_DELETE) ? WDATA_I[3:0] : 4'h0; // see RULE12
			if (WR_I)
			begin
				unique case (ADDR_I)
					`RA_WARN_MAX:   warn_max_ff  <= WDATA_I[15:0];
					`RA_WARN_MIN:   warn_min_ff  <= WDATA_I[15:0];
					`RA_ALARM_MAX:  alarm_max_ff <= WDATA_I[15:0];
					`RA_ALARM_MIN:  alarm_min_ff <= WDATA_I[15:0];
					`RA_CTRL:       ctrl_ff      <= WDATA_I[6:0];
					`RA_SPEED_SET:  speed_set_ff <= WDATA_I[15:0];
					`RA_TIMEOUT:    timeout_ff   <= WDATA_I[15:0];
					`RA_FILTER:     filter_ff    <= WDATA_I[7:0];
					`RA_SAMPLE_INT: sint_ff      <= WDATA_I[9:0];
					`RA_EVT_SEL:    evt_sel_ff   <= WDATA_I[4:0];
					default:        ;
				endcase
			end
		end
	end

	//==========================================================
	// power-on self test
	//==========================================================
	st_type     st_ff;
	logic [3:0] show_ff, code_ff;
	always_ff @(posedge CLK_SYS_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
		begin
			st_ff   <= ST_WAIT;
			show_ff <= 4'h0;
			code_ff <= `BLK_NONE;
		end
		else if (CE_I)
		begin
			unique case (st_ff)
				ST_WAIT:
					if (FW_LOAD_I)
					begin
						st_ff   <= ST_FAULT;
						code_ff <= `BLK_BOOT; // see RULE15
					end
					else if (SELFTEST_DONE_I && SELFTEST_FAULT_I != 7'h00)
					begin
						st_ff   <= ST_FAULT; // see RULE14
						code_ff <= fault_code(SELFTEST_FAULT_I); // see RULE15
					end
					else if (SELFTEST_DONE_I)
					begin
						st_ff   <= ST_SHOW; // see RULE13
						show_ff <= 4'(SHOW_TICKS);
					end
				ST_SHOW:
					if (tick_ff)
					begin
						show_ff <= show_ff - 4'h1;
						if (show_ff == 4'h1)
							st_ff <= ST_MEAS;
					end
				ST_MEAS:  ;
				ST_FAULT: ;
			endcase
		end
	end
	logic blink;
	accel_lamp_blinker u_blink (
		.clk_i   (CLK_SYS_I),
		.rst_n_i (RST_N_I),
		.ce_i    (CE_I),
		.tick_i  (tick_ff),
		.code_i  (code_ff),
		.lamp_o  (blink)
	);
	wire meas = (st_ff == ST_MEAS);

	//==========================================================
	// limit comparison and analysis filter
	//==========================================================
	logic               warn_ff, alarm_ff, alarm_d_ff;
	logic signed [15:0] held_ff, smp_ff;
	wire  signed [16:0] fdiff = 17'(ACCEL_I) - 17'(held_ff);
	wire         [16:0] fmag  = fdiff[16] ? 17'(-fdiff) : fdiff;
	wire         [16:0] fthr  = (filter_ff <= `ALM_FILT_OFF) ? 17'h0_0000 : 17'(filter_ff * `ALM_FILT_UNIT);
	always_ff @(posedge CLK_SYS_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
		begin
			warn_ff    <= 1'b0;
			alarm_ff   <= 1'b0;
			alarm_d_ff <= 1'b0;
			held_ff    <= 16'h0000;
			smp_ff     <= 16'h0000;
		end
		else if (CE_I)
		begin
			alarm_d_ff <= alarm_ff;
			if (ACCEL_VALID_I && meas)
			begin
				warn_ff  <= ACCEL_I > warn_max_ff || ACCEL_I < warn_min_ff; // see RULE23
				alarm_ff <= ACCEL_I > alarm_max_ff || ACCEL_I < alarm_min_ff; // see RULE23
				smp_ff   <= ACCEL_I;
				if (fmag >= fthr)
					held_ff <= ACCEL_I; // see RULE10
			end
		end
	end
	wire exceed = warn_ff || alarm_ff;

	//==========================================================
	// recording gate
	//==========================================================
	logic        speed_on_ff, rec_ff, timed_out_ff;
	logic [15:0] rec_sec_ff;
	logic        trig_on;
	always_comb
	begin
		unique case (trig)
			TRIG_AUTO:  trig_on = 1'b1;
			TRIG_GEAR:  trig_on = gear_s;
			TRIG_SPEED: trig_on = speed_on_ff;
			default:    trig_on = 1'b0;
		endcase
	end
	always_ff @(posedge CLK_SYS_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
			speed_on_ff <= 1'b0;
		else if (CE_I && AIRSPEED_VALID_I)
		begin
			if (!speed_on_ff && {1'b0, AIRSPEED_I} >= {1'b0, speed_set_ff} + `ALM_SPEED_HYST)
				speed_on_ff <= 1'b1; // see RULE5
			else if (speed_on_ff && {1'b0, AIRSPEED_I} + `ALM_SPEED_HYST <= {1'b0, speed_set_ff})
				speed_on_ff <= 1'b0; // see RULE5
		end
	end
	always_ff @(posedge CLK_SYS_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
		begin
			rec_ff       <= 1'b0;
			timed_out_ff <= 1'b0;
			rec_sec_ff   <= 16'h0000;
		end
		else if (CE_I)
		begin
			rec_ff <= meas && trig_on && !timed_out_ff; // see RULE4 RULE22
			if (!trig_on)
				timed_out_ff <= 1'b0;
			else if (ctrl_ff[`CF_TIMER] && rec_ff && rec_sec_ff >= timeout_ff)
				timed_out_ff <= 1'b1; // see RULE6
			if (!rec_ff)
				rec_sec_ff <= 16'h0000;
			else if (sec_ff && rec_sec_ff != 16'hFFFF)
				rec_sec_ff <= rec_sec_ff + 16'h0001;
		end
	end

	//==========================================================
	// signalization
	//==========================================================
	logic [3:0] hold_ff;
	logic       latch_ff;
	wire        exc_on = exceed || hold_ff != 4'h0;
	always_ff @(posedge CLK_SYS_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
		begin
			hold_ff  <= 4'h0;
			latch_ff <= 1'b0;
			ANNUNC_O <= 1'b0;
			LAMP_O   <= 1'b0;
		end
		else if (CE_I)
		begin
			if (exceed)
				hold_ff <= 4'(HOLD_TICKS); // see RULE20
			else if (tick_ff && hold_ff != 4'h0)
				hold_ff <= hold_ff - 4'h1;
			// a new alarm beats a simultaneous clear press
			if (amode == AM_BUTTON && alarm_ff && rec_ff)
				latch_ff <= 1'b1; // see RULE8
			else if (clr_s || amode != AM_BUTTON)
				latch_ff <= 1'b0; // see RULE8
			unique case (st_ff)
				ST_SHOW:
				begin
					ANNUNC_O <= 1'b1; // see RULE13
					LAMP_O   <= 1'b1;
				end
				ST_MEAS:
				begin
					unique case (amode)
						AM_EXCEEDED: ANNUNC_O <= exc_on; // see RULE1 RULE2 RULE20
						AM_BUTTON:   ANNUNC_O <= exc_on || latch_ff;
						default:     ANNUNC_O <= 1'b0; // see RULE7
					endcase
					unique case (lmode)
						LM_RECORDING: LAMP_O <= rec_ff; // see RULE9 RULE21
						LM_ALARM:     LAMP_O <= exc_on;
						default:      LAMP_O <= 1'b0;
					endcase
				end
				ST_FAULT:
				begin
					ANNUNC_O <= 1'b0;
					LAMP_O   <= blink; // see RULE15
				end
				ST_WAIT:
				begin
					ANNUNC_O <= 1'b0;
					LAMP_O   <= 1'b0;
				end
			endcase
		end
	end

	//==========================================================
	// sample store, cases, events, marker
	//==========================================================
	logic [9:0]    samp_ff, case_ln_ff;
	logic [15:0]   lines_ff, marker_ff;
	logic [4:0]    cases_ff, evt_cnt_ff, evt_wp_ff;
	logic          in_case_ff;
	logic [31:0]   optime_ff;
	event_rec_type evt_mem [0:`ALM_CASES_MAX-1];
	wire           new_alarm = alarm_ff && !alarm_d_ff && rec_ff;
	always_ff @(posedge CLK_SYS_I)
		if (CE_I && new_alarm)
			evt_mem[evt_wp_ff] <= '{value: smp_ff, optime: optime_ff}; // see RULE2 RULE18
	always_ff @(posedge CLK_SYS_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
		begin
			samp_ff     <= 10'h000;
			lines_ff    <= 16'h0000;
			cases_ff    <= 5'h00;
			case_ln_ff  <= 10'h000;
			in_case_ff  <= 1'b0;
			evt_cnt_ff  <= 5'h00;
			evt_wp_ff   <= 5'h00;
			optime_ff   <= 32'h0000_0000;
			marker_ff   <= `ALM_MARKER_RST;
			mark_d_ff   <= 1'b0;
			REC_WR_O    <= 1'b0;
			REC_DATA_O  <= '0;
		end
		else if (CE_I)
		begin
			mark_d_ff <= mark_s;
			if (mark_s && !mark_d_ff && rec_ff)
				marker_ff <= marker_ff + 16'h0001; // see RULE16
			if (meas && sec_ff)
				optime_ff <= optime_ff + 32'h0000_0001; // see RULE19
			REC_WR_O <= 1'b0;
			if (!rec_ff)
				samp_ff <= 10'h000; // see RULE3
			else if (tick_ff)
			begin
				samp_ff <= samp_ff + 10'h001;
				if (samp_ff + 10'h001 >= clamp_sint(sint_ff))
				begin
					samp_ff <= 10'h000;
					if (lines_ff < `ALM_LINES_MAX)
					begin
						REC_WR_O   <= 1'b1; // see RULE17
						REC_DATA_O <= '{in_case: in_case_ff, marker: marker_ff, value: held_ff};
						lines_ff   <= lines_ff + 16'h0001;
					end
					if (in_case_ff)
					begin
						case_ln_ff <= case_ln_ff + 10'h001;
						if (case_ln_ff + 10'h001 >= `ALM_CASE_LINES)
							in_case_ff <= 1'b0; // see RULE18
					end
				end
			end
			if (new_alarm)
			begin
				evt_wp_ff <= (evt_wp_ff == `ALM_CASES_MAX - 5'h01) ? 5'h00 : evt_wp_ff + 5'h01; // see RULE19
				if (evt_cnt_ff < `ALM_CASES_MAX)
					evt_cnt_ff <= evt_cnt_ff + 5'h01;
				if (cases_ff < `ALM_CASES_MAX && !in_case_ff)
				begin
					cases_ff   <= cases_ff + 5'h01;
					in_case_ff <= 1'b1;
					case_ln_ff <= 10'h000;
				end
			end
			if (DEL_O[0])
				lines_ff <= 16'h0000; // see RULE12
			if (DEL_O[1])
			begin
				// an alarm in the delete cycle survives the clear
				cases_ff   <= {4'h0, new_alarm};
				in_case_ff <= new_alarm;
			end
			if (DEL_O[2])
				evt_cnt_ff <= {4'h0, new_alarm};
		end
	end

	//==========================================================
	// read port and status
	//==========================================================
	event_rec_type sel_evt;
	assign sel_evt = evt_mem[(evt_sel_ff < `ALM_CASES_MAX) ? evt_sel_ff : 5'h00];
	always_ff @(posedge CLK_SYS_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
		begin
			RDATA_O      <= 32'h0000_0000;
			REC_ACTIVE_O <= 1'b0;
			MEASURING_O  <= 1'b0;
		end
		else if (CE_I)
		begin
			REC_ACTIVE_O <= rec_ff;
			MEASURING_O  <= meas;
			RDATA_O      <= 32'h0000_0000;
			if (RD_I)
			begin
				unique case (ADDR_I)
					`RA_WARN_MAX:   RDATA_O <= 32'(warn_max_ff);
					`RA_WARN_MIN:   RDATA_O <= 32'(warn_min_ff);
					`RA_ALARM_MAX:  RDATA_O <= 32'(alarm_max_ff);
					`RA_ALARM_MIN:  RDATA_O <= 32'(alarm_min_ff);
					`RA_CTRL:       RDATA_O <= 32'(ctrl_ff);
					`RA_SPEED_SET:  RDATA_O <= 32'(speed_set_ff);
					`RA_TIMEOUT:    RDATA_O <= 32'(timeout_ff);
					`RA_FILTER:     RDATA_O <= 32'(filter_ff);
					`RA_SAMPLE_INT: RDATA_O <= 32'(sint_ff);
					`RA_STATUS:     RDATA_O <= {8'h00, 3'h0, evt_cnt_ff, 3'h0, cases_ff, code_ff,
					                            st_ff, latch_ff, rec_ff};
					`RA_MARKER:     RDATA_O <= 32'(marker_ff);
					`RA_LINES:      RDATA_O <= 32'(lines_ff);
					`RA_EVT_SEL:    RDATA_O <= 32'(evt_sel_ff);
					`RA_EVT_VAL:    RDATA_O <= 32'(sel_evt.value);
					`RA_EVT_TIME:   RDATA_O <= sel_evt.optime;
					`RA_OPTIME:     RDATA_O <= optime_ff;
					default:        RDATA_O <= 32'h0000_0000;
				endcase
			end
		end
	end

	//==========================================================
	// checks
	//==========================================================
	a_warn_annunc: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I) // see RULE1
		CE_I && meas && amode == AM_EXCEEDED && warn_ff |=> ANNUNC_O)
		else $error("warning exceedance did not raise annunciator");
	a_off_silent: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I) // see RULE7
		CE_I && meas && amode == AM_OFF |=> !ANNUNC_O)
		else $error("annunciator active in off mode");
	a_hold_second: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I) // see RULE20
		CE_I && meas && amode == AM_EXCEEDED && hold_ff != 4'h0 |=> ANNUNC_O)
		else $error("annunciator dropped during hold");
	a_latch_kept: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I) // see RULE8
		CE_I && latch_ff && !clr_s && amode == AM_BUTTON |=> latch_ff)
		else $error("alarm latch released without clear");
	a_no_idle_store: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I) // see RULE3
		REC_WR_O |-> $past(rec_ff))
		else $error("sample stored while recording inactive");
	a_speed_start: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I) // see RULE5
		$rose(speed_on_ff) |-> {1'b0, $past(AIRSPEED_I)} >= {1'b0, $past(speed_set_ff)} + `ALM_SPEED_HYST)
		else $error("speed trigger below set plus hysteresis");
	a_timeout_stop: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I) // see RULE6
		CE_I && timed_out_ff |=> !rec_ff)
		else $error("recording continued after timeout");
	a_show_both: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I) // see RULE13
		CE_I && st_ff == ST_SHOW |=> ANNUNC_O && LAMP_O)
		else $error("power-on indication missing");
	a_marker_step: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I) // see RULE16
		marker_ff != $past(marker_ff) |-> marker_ff == $past(marker_ff) + 16'h0001 && $past(rec_ff))
		else $error("marker changed other than by one while recording");
	a_lines_cap: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I) // see RULE17
		lines_ff <= `ALM_LINES_MAX)
		else $error("line store overrun");
endmodule

// ---- rtl/accel_pin_sync.sv ----
`timescale 1ns/10ps
module accel_pin_sync #(
	parameter int W = 3
) (
	input  wire logic         clk_i,
	input  wire logic         rst_n_i,
	input  wire logic         ce_i,
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);
	logic [W-1:0] meta_ff;
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			meta_ff <= '0;
			q_o     <= '0;
		end
		else if (ce_i)
		begin
			meta_ff <= d_i;
			q_o     <= meta_ff;
		end
	end
endmodule

// ---- rtl/accel_pkg.sv ----
package accel_pkg;
	typedef enum logic [1:0] {TRIG_AUTO = 2'b00, TRIG_GEAR = 2'b01, TRIG_SPEED = 2'b10} trig_type;
	typedef enum logic [1:0] {AM_OFF = 2'b00, AM_EXCEEDED = 2'b01, AM_BUTTON = 2'b10} alarm_mode_type;
	typedef enum logic [1:0] {LM_OFF = 2'b00, LM_RECORDING = 2'b01, LM_ALARM = 2'b10} lamp_mode_type;
	typedef enum logic [1:0] {ST_WAIT = 2'b00, ST_SHOW = 2'b01, ST_MEAS = 2'b10, ST_FAULT = 2'b11} st_type;
	typedef struct packed {
		logic               in_case;
		logic        [15:0] marker;
		logic signed [15:0] value;
	} rec_word_type;
	typedef struct packed {
		logic signed [15:0] value;
		logic        [31:0] optime;
	} event_rec_type;
endpackage

// ---- sim/cockpit_model.sv ----
`timescale 1ns/10ps
module cockpit_model (
	input  wire logic clk_i,
	output logic      gear_o,
	output logic      clear_o,
	output logic      marker_o,
	output logic      done_o
);
	initial
	begin
		gear_o = 1'b0;
		clear_o = 1'b0;
		marker_o = 1'b0;
		done_o = 1'b0;
	end
	task automatic set_pins(input logic g, input logic d);
		@(posedge clk_i);
		gear_o <= g;
		done_o <= d;
	endtask
	// held longer than the input synchronizer
	task automatic press_marker();
		@(posedge clk_i);
		marker_o <= 1'b1;
		repeat (4) @(posedge clk_i);
		marker_o <= 1'b0;
	endtask
	// pilot releases the alarm latch
	task automatic press_clear();
		@(posedge clk_i);
		clear_o <= 1'b1;
		repeat (4) @(posedge clk_i);
		clear_o <= 1'b0;
	endtask
endmodule

// ---- sim/testbench.sv ----
`timescale 1ns/10ps
`include "accel_defs.svh"
module testbench;
	import accel_pkg::*;
	logic               clk, rst_n, wr, rd, vld, gear, clr, mrk, done, svld, recwr;
	logic        [15:0] spd;
	logic        [6:0]  fault;
	rec_word_type       rdat;
	logic               annunc, lamp, rec_act, meas;
	logic        [7:0]  addr;
	logic        [31:0] wdata, rdata, r;
	logic signed [15:0] accel;
	logic        [3:0]  del;
	int                 bad_count, compares;
	cockpit_model cockpit_u (.clk_i(clk), .gear_o(gear), .clear_o(clr), .marker_o(mrk), .done_o(done));
	accel_limit_monitor_recorder #(.TICK_CYCLES(10)) dut_u (
		.CLK_SYS_I(clk), .RST_N_I(rst_n), .CE_I(1'b1), .ADDR_I(addr), .WDATA_I(wdata),
		.WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .ACCEL_I(accel), .ACCEL_VALID_I(vld),
		.AIRSPEED_I(spd), .AIRSPEED_VALID_I(svld), .GEAR_SW_I(gear), .CLEAR_BTN_I(clr),
		.MARKER_BTN_I(mrk), .SELFTEST_DONE_I(done), .SELFTEST_FAULT_I(fault), .FW_LOAD_I(1'b0),
		.ANNUNC_O(annunc), .LAMP_O(lamp), .REC_ACTIVE_O(rec_act), .REC_WR_O(recwr), .REC_DATA_O(rdat),
		.DEL_O(del), .MEASURING_O(meas));
	// ====================
	// bus and compare
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		compares++;
		if (got !== exp)
		begin
			bad_count++;
			$display("unexpected %0t %s", $time, what);
		end
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask
	task automatic sample(input logic signed [15:0] v);
		@(posedge clk);
		accel <= v;
		vld <= 1'b1;
		@(posedge clk);
		vld <= 1'b0;
	endtask
	task automatic airspeed(input logic [15:0] v, input logic exp, input string what);
		@(posedge clk);
		spd <= v;
		svld <= 1'b1;
		@(posedge clk);
		svld <= 1'b0;
		repeat (3) @(posedge clk);
		#1 chk(rec_act, exp, what);
	endtask
	// ====================
	// scenarios
	task automatic t_show();
		cockpit_u.set_pins(1'b0, 1'b1);
		repeat (5) @(posedge clk);
		#1 chk({annunc, lamp}, 2'b11, "show phase");
		repeat (200) if (meas !== 1'b1) @(posedge clk);
		#1 chk(meas, 1'b1, "not measuring");
	endtask
	task automatic t_regs();
		rd_reg(`RA_CTRL, r);
		chk(r, 32'h0000_0015, "ctrl reset");
		rd_reg(8'h80, r);
		chk(r, 32'h0000_0000, "unmapped read");
		rd_reg(`RA_MARKER, r);
		chk(r, 32'h0000_0001, "marker reset");
		wr_reg(`RA_FILTER, 32'h0000_0003);
		rd_reg(`RA_FILTER, r);
		chk(r, 32'h0000_0003, "filter");
	endtask
	task automatic t_warn();
		sample(16'sh0168);
		repeat (3) @(posedge clk);
		#1 chk(annunc, 1'b1, "warning silent");
		chk(rec_act, 1'b0, "recording on ground");
		chk(lamp, 1'b0, "lamp while idle");
		sample(16'sh0064);
		repeat (60) @(posedge clk);
		#1 chk(annunc, 1'b1, "hold too short");
		repeat (70) @(posedge clk);
		#1 chk(annunc, 1'b0, "hold too long");
	endtask
	task automatic t_off();
		wr_reg(`RA_CTRL, 32'h0000_0011);
		sample(16'sh01F4);
		repeat (4) @(posedge clk);
		#1 chk(annunc, 1'b0, "mode off sounds");
		sample(16'sh0000);
		wr_reg(`RA_CTRL, 32'h0000_0015);
	endtask
	task automatic t_marker();
		cockpit_u.set_pins(1'b1, 1'b1);
		repeat (6) @(posedge clk);
		#1 chk(rec_act, 1'b1, "gear start");
		chk(lamp, 1'b1, "lamp recording");
		cockpit_u.press_marker();
		repeat (4) @(posedge clk);
		rd_reg(`RA_MARKER, r);
		chk(r, 32'h0000_0002, "marker step");
		for (int i = 0; i < 12 && recwr !== 1'b1; i++)
		begin
			@(posedge clk);
			#1;
		end
		chk(recwr, 1'b1, "no line stored");
		chk(rdat.marker, 16'h0002, "line marker");
	endtask
	task automatic t_button();
		wr_reg(`RA_CTRL, 32'h0000_0019);
		sample(16'sh01F4);
		sample(16'sh0000);
		repeat (150) @(posedge clk);
		#1 chk(annunc, 1'b1, "latch lost");
		cockpit_u.press_clear();
		repeat (3) @(posedge clk);
		#1 chk(annunc, 1'b0, "clear ignored");
		rd_reg(`RA_EVT_VAL, r);
		chk(r, 32'h0000_01F4, "event value");
		wr_reg(`RA_CTRL, 32'h0000_0015);
	endtask
	task automatic t_speed();
		wr_reg(`RA_CTRL, 32'h0000_0016);
		airspeed(16'h0066, 1'b0, "early start");
		airspeed(16'h0067, 1'b1, "start");
		airspeed(16'h0062, 1'b1, "early stop");
		airspeed(16'h0061, 1'b0, "stop");
		wr_reg(`RA_CTRL, 32'h0000_0015);
	endtask
	task automatic t_delete();
		wr_reg(`RA_DELETE, 32'h0000_0005);
		#1 chk(del, 4'h5, "delete select");
		rd_reg(`RA_STATUS, r);
		chk(r[20:8], 32'h0000_0001, "delete scope");
	endtask
	task automatic t_fault();
		int n;
		logic prev;
		@(posedge clk);
		rst_n <= 1'b0;
		fault <= 7'h0C;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		n = 0;
		prev = 1'b0;
		repeat (220)
		begin
			@(posedge clk);
			#1 if (lamp === 1'b1 && prev !== 1'b1) n++;
			prev = lamp;
		end
		chk(meas, 1'b0, "measuring with fault");
		chk(n, 4, "blink count");
	endtask
	task automatic conclude();
		$display("bad_count=%0d compares=%0d", bad_count, compares);
		if (bad_count == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// ====================
	// clock, reset, run
	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	initial
	begin
		#(40 * 5000);
		bad_count++;
		conclude();
	end
	initial
	begin
		{rst_n, wr, rd, vld, svld, addr, wdata, accel, spd, fault} = '0;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		t_show();
		t_regs();
		t_warn();
		t_off();
		t_marker();
		t_button();
		t_speed();
		t_delete();
		t_fault();
		conclude();
	end
endmodule
